// *** logic/tucgp_pkg.sv ***
// Constants and types shared by the timer unit clock gate and prescaler
package tucgp_pkg;
  // ==========================================================
  // Bus geometry: byte address is four times the register index
  localparam int ADR_W = 22;
  localparam int IDX_W = 20;
  localparam logic [19:0] IDX_PER = 20'hf00f0;
  localparam logic [19:0] IDX_PSC = 20'hf01b6;
  localparam logic [19:0] IDX_CTL = 20'hf0200;
  localparam logic [19:0] IDX_DAT = 20'hf0210;
  localparam logic [19:0] IDX_CNT = 20'hf0220;
  localparam logic [19:0] IDX_RUN = 20'hf0230;
  // ==========================================================
  // Peripheral clock enable
  localparam logic [7:0] PER_RST = 8'h00;
  localparam logic [7:0] PER_MASK = 8'h75;
  localparam int GATE_BIT = 0;
  // ==========================================================
  // Prescaler select
  localparam logic [15:0] PSC_RST = 16'h0000;
  localparam logic [15:0] PSC_MASK = 16'h33ff;
  localparam int F0_LO = 0;
  localparam int F1_LO = 4;
  localparam int F2_LO = 8;
  localparam int F3_LO = 12;
  localparam logic [3:0] FIELD_UNDIV = 4'h0;
  localparam logic [3:0] CK2_EXP [4] = '{4'h1, 4'h2, 4'h4, 4'h6};
  localparam logic [3:0] CK3_EXP [4] = '{4'h8, 4'ha, 4'hc, 4'he};
  localparam int TICK_N = 16;
  localparam int PSC_W = 15;
  // ==========================================================
  // Channels
  localparam int NCH = 4;
  localparam int CTL_W = 6;
  localparam int CTL_CAP_BIT = 0;
  localparam int CTL_EDGE_LO = 1;
  localparam int CTL_CKS_LO = 4;
  localparam logic [5:0] CTL_RST = 6'h00;
  localparam logic [15:0] CNT_RST = 16'hffff;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [15:0] DAT_RST = 16'h0000;
  localparam logic [3:0] RUN_RST = 4'h0;
  typedef enum logic [1:0] {
    TUCGP_EDGE_FALL = 2'b00,
    TUCGP_EDGE_RISE = 2'b01,
    TUCGP_EDGE_BOTH = 2'b10,
    TUCGP_EDGE_NONE = 2'b11
  } tucgp_edge_t;
  typedef enum logic [1:0] {
    TUCGP_CK0 = 2'b00,
    TUCGP_CK1 = 2'b01,
    TUCGP_CK2 = 2'b10,
    TUCGP_CK3 = 2'b11
  } tucgp_ck_t;
endpackage

// *** logic/tucgp_tick_if.sv ***
// Prescaler enable ticks and unit reset passed between design modules
`timescale 1ns/1ps
interface tucgp_tick_if;
  logic clear;
  logic [tucgp_pkg::TICK_N-1:0] tick;
  modport src (input clear, output tick);
  modport snk (output clear, input tick);
endinterface

// *** logic/tucgp_prescaler.sv ***
// Free running prescaler producing one-cycle divide enables
`timescale 1ns/1ps
module tucgp_prescaler
(
  input wire logic clk,
  input wire logic rst_b,
  tucgp_tick_if.src tk
);
  // ==========================================================
  // Counter
  logic [tucgp_pkg::PSC_W-1:0] cnt;
  logic [tucgp_pkg::PSC_W-1:0] next_cnt;

  always_comb
  begin
    next_cnt = cnt + {{(tucgp_pkg::PSC_W-1){1'b0}}, 1'b1}; // RULE_20
    if (tk.clear)
    begin
      next_cnt = '0; // RULE_20
    end
  end

  always_ff @(posedge clk)
  begin
    cnt <= next_cnt;
  end

  // ==========================================================
  // Carry enables, one per divide ratio
  assign tk.tick[0] = ~tk.clear; // RULE_11
  for (genvar k = 1; k < tucgp_pkg::TICK_N; k++)
  begin : g_tick
    assign tk.tick[k] = ~tk.clear & (&cnt[k-1:0]); // RULE_19
  end

  // ==========================================================
  // Checks
  tick_half_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_19
    tk.tick[1] |=> !tk.tick[1])
    else $error("divide by two enable stayed high");
  tick_quarter_a: assert property (@(posedge clk) disable iff (!rst_b || tk.clear) // RULE_11
    tk.tick[2] |=> !tk.tick[2] [*3] ##1 tk.tick[2])
    else $error("divide by four enable has wrong period");
endmodule // tucgp_prescaler

// *** logic/tucgp_timer_unit.sv ***
// Timer unit top: clock gate, prescaler select, channels, bus slave
// What this block does
// RULE_01: In capture mode, a capture trigger copies the channel count into its data register.
// RULE_02: Capture trigger is the pin edge chosen in the channel mode register.
// RULE_03: Software sets the clock gate bit 0 before using the unit.
// RULE_04: Gate low stops the clock, blocks writes and holds the unit reset.
// RULE_05: Gate low ignores unit register writes and reads return defaults.
// RULE_06: Software writes zero to enable bits 1, 3 and 7.
// RULE_07: System reset clears the enable register to zero.
// RULE_08: Enable register takes bit-wise and whole byte writes.
// RULE_09: Prescaler bits 7-4 pick shared clock one, bits 3-0 shared clock zero.
// RULE_10: Bits 9-8 pick shared clock two, 13-12 shared clock three.
// RULE_11: Four-bit field value k divides the system clock by two to k.
// RULE_12: Software rewrites a field only while its channels are stopped.
// RULE_13: Prescaler resets to zero and takes only full 16-bit writes.
// RULE_14: Software writes zero to prescaler bits 15, 14, 11 and 10.
// RULE_15: Software stops all channels before changing the system clock.
// RULE_16: Undivided clock with data zero gives no interrupt event.
// RULE_17: Software writes unimplemented bits only with reset values.
// RULE_18: Clearing the gate forces every count to all ones, as reset does.
// RULE_19: Divided clocks are one-cycle enable pulses on system clock edges.
// RULE_20: A free running counter reset with the unit makes the enables.
//
// Added by the designer: the Wishbone interface to the registers.
`timescale 1ns/1ps
module tucgp_timer_unit
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [tucgp_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [tucgp_pkg::NCH-1:0] channel_timer_input_pin,
  output logic [tucgp_pkg::NCH-1:0] channel_event,
  output logic [7:0] peripheral_clock_enable
);
  // ==========================================================
  // Bus slave and unit-level registers
  logic [7:0] per;
  logic [7:0] next_per;
  logic [15:0] psc;
  logic [15:0] next_psc;
  logic [3:0] run;
  logic [3:0] next_run;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic ack;
  logic next_ack;
  logic gate;
  logic unit_rst;
  logic hit;
  logic commit;
  logic wr_ok;
  logic [tucgp_pkg::IDX_W-1:0] idx;
  logic [1:0] sel_ch;
  logic is_per;
  logic is_psc;
  logic is_run;
  logic is_ctl;
  logic is_dat;
  logic is_cnt;
  logic [3:0][15:0] cnt_all;
  logic [3:0][15:0] dat_all;
  logic [3:0][5:0] ctl_all;
  logic [3:0] ck;

  assign gate = per[tucgp_pkg::GATE_BIT];
  assign unit_rst = ~rst_b | ~gate; // RULE_04
  assign hit = wb_cyc_i & wb_stb_i;
  assign commit = hit & ack & wb_we_i;
  assign wr_ok = commit & gate; // RULE_05
  assign idx = wb_adr_i[tucgp_pkg::ADR_W-1:2];
  assign sel_ch = idx[1:0];
  assign is_per = idx == tucgp_pkg::IDX_PER;
  assign is_psc = idx == tucgp_pkg::IDX_PSC;
  assign is_run = idx == tucgp_pkg::IDX_RUN;
  assign is_ctl = idx[19:2] == tucgp_pkg::IDX_CTL[19:2];
  assign is_dat = idx[19:2] == tucgp_pkg::IDX_DAT[19:2];
  assign is_cnt = idx[19:2] == tucgp_pkg::IDX_CNT[19:2];

  always_comb
  begin
    next_ack = hit & ~ack;
    next_rdata = rdata;
    if (hit && !ack)
    begin
      if (is_per)
        next_rdata = {24'h000000, per};
      else if (is_psc)
        next_rdata = {16'h0000, psc};
      else if (is_run)
        next_rdata = {28'h0000000, run};
      else if (is_ctl)
        next_rdata = {26'h0, ctl_all[sel_ch]};
      else if (is_dat)
        next_rdata = {16'h0000, dat_all[sel_ch]};
      else if (is_cnt)
        next_rdata = {16'h0000, cnt_all[sel_ch]};
      else
        next_rdata = 32'h00000000;
    end
    next_per = per;
    if (commit && is_per && wb_sel_i[0])
    begin
      next_per = wb_dat_i[7:0] & tucgp_pkg::PER_MASK; // RULE_08
    end
    next_psc = psc;
    if (wr_ok && is_psc && (&wb_sel_i[1:0]))
    begin
      next_psc = wb_dat_i[15:0] & tucgp_pkg::PSC_MASK; // RULE_13
    end
    next_run = run;
    if (wr_ok && is_run && wb_sel_i[0])
    begin
      next_run = wb_dat_i[3:0];
    end
    if (unit_rst)
    begin
      next_psc = tucgp_pkg::PSC_RST; // RULE_04
      next_run = tucgp_pkg::RUN_RST;
    end
    if (!rst_b)
    begin
      next_per = tucgp_pkg::PER_RST; // RULE_07
      next_ack = 1'b0;
      next_rdata = 32'h00000000;
    end
  end

  always_ff @(posedge clk)
  begin
    per <= next_per;
    psc <= next_psc;
    run <= next_run;
    ack <= next_ack;
    rdata <= next_rdata;
  end

  assign wb_ack_o = ack;
  assign wb_dat_o = rdata;
  assign peripheral_clock_enable = per;

  // ==========================================================
  // Shared clock selection
  tucgp_tick_if u_tick ();
  assign u_tick.clear = unit_rst; // RULE_20

  tucgp_prescaler u_psc
  (
    .clk(clk),
    .rst_b(rst_b),
    .tk(u_tick.src)
  );

  assign ck[0] = u_tick.tick[psc[tucgp_pkg::F0_LO +: 4]]; // RULE_09
  assign ck[1] = u_tick.tick[psc[tucgp_pkg::F1_LO +: 4]]; // RULE_09
  assign ck[2] = u_tick.tick[tucgp_pkg::CK2_EXP[psc[tucgp_pkg::F2_LO +: 2]]]; // RULE_10
  assign ck[3] = u_tick.tick[tucgp_pkg::CK3_EXP[psc[tucgp_pkg::F3_LO +: 2]]]; // RULE_10

  // ==========================================================
  // Channels
  for (genvar n = 0; n < tucgp_pkg::NCH; n++)
  begin : g_ch
    logic [15:0] cnt;
    logic [15:0] next_cnt;
    logic [15:0] dat;
    logic [15:0] next_dat;
    logic [5:0] ctl;
    logic [5:0] next_ctl;
    logic pin_q;
    logic next_pin_q;
    logic run_q;
    logic next_run_q;
    logic evt;
    logic next_evt;
    logic [1:0] choice;
    logic trig;
    logic cnt_en;
    logic start;
    logic undiv;
    logic wr_ctl;
    logic wr_dat;

    assign wr_ctl = wr_ok && is_ctl && sel_ch == 2'(n) && wb_sel_i[0];
    assign wr_dat = wr_ok && is_dat && sel_ch == 2'(n) && (&wb_sel_i[1:0]);

    always_comb
    begin
      choice = ctl[tucgp_pkg::CTL_CKS_LO +: 2];
      if (n % 2 == 0)
      begin
        choice[1] = 1'b0; // RULE_10
      end
      case (tucgp_pkg::tucgp_edge_t'(ctl[tucgp_pkg::CTL_EDGE_LO +: 2]))
        tucgp_pkg::TUCGP_EDGE_FALL: trig = pin_q & ~channel_timer_input_pin[n]; // RULE_02
        tucgp_pkg::TUCGP_EDGE_RISE: trig = ~pin_q & channel_timer_input_pin[n]; // RULE_02
        tucgp_pkg::TUCGP_EDGE_BOTH: trig = pin_q ^ channel_timer_input_pin[n]; // RULE_02
        default: trig = 1'b0;
      endcase
      cnt_en = run[n] & ck[choice];
      start = run[n] & ~run_q;
      undiv = (choice == tucgp_pkg::TUCGP_CK0
        && psc[tucgp_pkg::F0_LO +: 4] == tucgp_pkg::FIELD_UNDIV)
        || (choice == tucgp_pkg::TUCGP_CK1
        && psc[tucgp_pkg::F1_LO +: 4] == tucgp_pkg::FIELD_UNDIV);
      next_ctl = ctl;
      next_dat = dat;
      next_cnt = cnt;
      next_evt = 1'b0;
      next_pin_q = channel_timer_input_pin[n];
      next_run_q = run[n];
      if (wr_ctl)
        next_ctl = wb_dat_i[5:0];
      if (wr_dat)
        next_dat = wb_dat_i[15:0];
      if (ctl[tucgp_pkg::CTL_CAP_BIT])
      begin
        if (start)
          next_cnt = tucgp_pkg::CNT_ZERO;
        else if (run[n] && trig)
        begin
          next_dat = cnt; // RULE_01
          next_cnt = tucgp_pkg::CNT_ZERO;
        end
        else if (cnt_en)
          next_cnt = cnt + tucgp_pkg::CNT_ONE;
      end
      else
      begin
        if (start)
          next_cnt = dat;
        else if (cnt_en)
        begin
          if (cnt == tucgp_pkg::CNT_ZERO)
          begin
            next_cnt = dat;
            next_evt = ~(undiv && dat == tucgp_pkg::CNT_ZERO); // RULE_16
          end
          else
            next_cnt = cnt - tucgp_pkg::CNT_ONE;
        end
      end
      if (unit_rst)
      begin
        next_ctl = tucgp_pkg::CTL_RST; // RULE_04
        next_dat = tucgp_pkg::DAT_RST;
        next_cnt = tucgp_pkg::CNT_RST; // RULE_18
        next_evt = 1'b0;
        next_pin_q = 1'b0;
        next_run_q = 1'b0;
      end
    end

    always_ff @(posedge clk)
    begin
      ctl <= next_ctl;
      dat <= next_dat;
      cnt <= next_cnt;
      evt <= next_evt;
      pin_q <= next_pin_q;
      run_q <= next_run_q;
    end

    assign cnt_all[n] = cnt;
    assign dat_all[n] = dat;
    assign ctl_all[n] = ctl;
    assign channel_event[n] = evt;
  end

  // ==========================================================
  // Checks
  gate_cnt_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_18
    !gate |=> (cnt_all[0] == tucgp_pkg::CNT_RST && cnt_all[3] == tucgp_pkg::CNT_RST))
    else $error("count not forced to all ones while gated");
  per_reset_a: assert property (@(posedge clk) // RULE_07
    !rst_b |=> per == tucgp_pkg::PER_RST && !ack)
    else $error("enable register not cleared by reset");
  per_write_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_08
    commit && is_per && wb_sel_i[0] |=> per == ($past(wb_dat_i[7:0]) & tucgp_pkg::PER_MASK))
    else $error("enable register byte write lost");
  psc_partial_a: assert property (@(posedge clk) disable iff (!rst_b || !gate) // RULE_13
    commit && is_psc && !(&wb_sel_i[1:0]) |=> $stable(psc))
    else $error("prescaler took a partial write");
  psc_blocked_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_05
    !gate |-> ##1 (psc == tucgp_pkg::PSC_RST && run == tucgp_pkg::RUN_RST))
    else $error("unit register changed while gated");
  psc_reserved_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_14
    (psc & ~tucgp_pkg::PSC_MASK) == 16'h0000)
    else $error("reserved prescaler bits set");
  ck_zero_a: assert property (@(posedge clk) disable iff (!rst_b || !gate) // RULE_09
    psc[3:0] == tucgp_pkg::FIELD_UNDIV |-> ck[0])
    else $error("undivided shared clock not continuous");
  capture_copy_a: assert property (@(posedge clk) disable iff (!rst_b || !gate) // RULE_01
    g_ch[2].ctl[tucgp_pkg::CTL_CAP_BIT] && run[2] && !g_ch[2].start && g_ch[2].trig
    |=> dat_all[2] == $past(cnt_all[2]) && cnt_all[2] == tucgp_pkg::CNT_ZERO)
    else $error("capture did not copy the count");
  no_event_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_16
    g_ch[0].undiv && dat_all[0] == tucgp_pkg::CNT_ZERO && !g_ch[0].wr_dat
    && !g_ch[0].wr_ctl && !commit |=> !channel_event[0])
    else $error("event raised with undivided clock and zero data");
  ack_once_a: assert property (@(posedge clk) disable iff (!rst_b)
    ack |=> !ack)
    else $error("acknowledge held for two cycles");
  capture_c: cover property (@(posedge clk) disable iff (!rst_b)
    g_ch[2].ctl[tucgp_pkg::CTL_CAP_BIT] && run[2] && g_ch[2].trig);
  event_c: cover property (@(posedge clk) disable iff (!rst_b) channel_event[1]);
  gate_drop_c: cover property (@(posedge clk) disable iff (!rst_b) $fell(gate) && run != 4'h0);
endmodule // tucgp_timer_unit

// *** testbench/tucgp_timer_unit_tb.sv ***
// Self-checking bench for the timer unit clock gate, prescaler and capture path
`timescale 1ns/1ps
module tucgp_timer_unit_tb;
  // ==========================================================
  // Signals
  logic clk;
  logic rst_b;
  logic [tucgp_pkg::ADR_W-1:0] wb_adr_i;
  logic [31:0] wb_dat_i;
  logic [3:0] wb_sel_i;
  logic wb_we_i;
  logic wb_cyc_i;
  logic wb_stb_i;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [3:0] pin;
  logic [3:0] ev;
  logic [7:0] pce;
  logic [31:0] q;
  int n_errors;
  int comparisons;

  tucgp_timer_unit i_tucgp_timer_unit
  (
    .clk(clk),
    .rst_b(rst_b),
    .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i),
    .wb_we_i(wb_we_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .channel_timer_input_pin(pin),
    .channel_event(ev),
    .peripheral_clock_enable(pce)
  );

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ==========================================================
  // Reporting
  task automatic final_report();
    $display("Mismatches %0d, comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // ==========================================================
  // Bus cycles
  task automatic xfer(input logic [19:0] idx, input logic we, input logic [31:0] d,
                      input logic [3:0] sel);
    int n;
    n = 0;
    @(posedge clk);
    wb_adr_i <= {idx, 2'b00};
    wb_we_i <= we;
    wb_dat_i <= d;
    wb_sel_i <= sel;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    if (wb_ack_o !== 1'b1)
    begin
      n_errors++;
      $display("BAD t=%0t no ack got=%h exp=%h", $time, wb_ack_o, 1'b1);
      final_report();
    end
  endtask

  task automatic wr(input logic [19:0] idx, input logic [31:0] d, input logic [3:0] sel);
    xfer(idx, 1'b1, d, sel);
  endtask

  task automatic rc(input logic [19:0] idx, input logic [31:0] exp);
    xfer(idx, 1'b0, 32'h0000_0000, 4'hf);
    cmp(q, exp);
  endtask

  // ==========================================================
  // Interval period measurement
  task automatic waitev(input int ch, output int c);
    c = 0;
    do
    begin
      @(posedge clk);
      c++;
    end
    while (ev[ch] !== 1'b1 && c < 9000);
    if (ev[ch] !== 1'b1)
    begin
      n_errors++;
      $display("BAD t=%0t no event got=%h exp=%h", $time, ev, 4'hf);
      final_report();
    end
  endtask

  task automatic iv(input int ch, input logic [1:0] cks, input logic [15:0] psc,
                    input logic [15:0] d, input int ep);
    int c;
    wr(tucgp_pkg::IDX_RUN, 32'h0, 4'h1);
    wr(tucgp_pkg::IDX_PSC, {16'h0000, psc}, 4'h3);
    wr(tucgp_pkg::IDX_CTL + 20'(ch), {26'h0, cks, 4'h6}, 4'h1);
    wr(tucgp_pkg::IDX_DAT + 20'(ch), {16'h0000, d}, 4'h3);
    wr(tucgp_pkg::IDX_RUN, 32'h1 << ch, 4'h1);
    waitev(ch, c);
    waitev(ch, c);
    cmp(32'(c), 32'(ep));
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    int c;
    rst_b = 1'b0;
    wb_adr_i = '0;
    wb_dat_i = 32'h0;
    wb_sel_i = 4'h0;
    wb_we_i = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    pin = 4'h0;
    n_errors = 0;
    comparisons = 0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    rc(tucgp_pkg::IDX_PER, 32'h0);
    cmp({24'h0, pce}, 32'h0);
    rc(tucgp_pkg::IDX_PSC, 32'h0);
    rc(tucgp_pkg::IDX_CNT, 32'hffff);
    wr(tucgp_pkg::IDX_PSC, 32'h0012, 4'h3);
    wr(tucgp_pkg::IDX_CTL, 32'h01, 4'h1);
    rc(tucgp_pkg::IDX_PSC, 32'h0);
    rc(tucgp_pkg::IDX_CTL, 32'h0);
    wr(tucgp_pkg::IDX_PER, 32'hff, 4'h0);
    rc(tucgp_pkg::IDX_PER, 32'h0);
    wr(tucgp_pkg::IDX_PER, 32'hff, 4'h1);
    rc(tucgp_pkg::IDX_PER, 32'h75);
    cmp({24'h0, pce}, 32'h75);
    wr(tucgp_pkg::IDX_PER, 32'h01, 4'h1);
    wr(tucgp_pkg::IDX_PSC, 32'hffff, 4'h3);
    rc(tucgp_pkg::IDX_PSC, 32'h33ff);
    wr(tucgp_pkg::IDX_PSC, 32'h0000, 4'h1);
    rc(tucgp_pkg::IDX_PSC, 32'h33ff);
    wr(20'h00123, 32'hff, 4'hf);
    rc(20'h00123, 32'h0);
    iv(0, 2'd0, 16'h0000, 16'd3, 4);
    iv(0, 2'd0, 16'h0001, 16'd3, 8);
    iv(0, 2'd0, 16'h0005, 16'd3, 128);
    iv(1, 2'd1, 16'h0030, 16'd3, 32);
    iv(1, 2'd2, 16'h0000, 16'd1, 4);
    iv(1, 2'd2, 16'h0100, 16'd1, 8);
    iv(1, 2'd2, 16'h0200, 16'd1, 32);
    iv(1, 2'd2, 16'h0300, 16'd1, 128);
    iv(3, 2'd3, 16'h0000, 16'd1, 512);
    iv(3, 2'd3, 16'h1000, 16'd1, 2048);
    iv(0, 2'd2, 16'h0302, 16'd1, 8);
    wr(tucgp_pkg::IDX_RUN, 32'h0, 4'h1);
    wr(tucgp_pkg::IDX_PSC, 32'h0, 4'h3);
    wr(tucgp_pkg::IDX_DAT, 32'h0, 4'h3);
    wr(tucgp_pkg::IDX_RUN, 32'h1, 4'h1);
    c = 0;
    repeat (40)
    begin
      @(posedge clk);
      c += int'(ev[0] === 1'b1);
    end
    cmp(32'(c), 32'h0);
    // Capture on each edge choice: rising half then falling half
    for (int e = 0; e < 4; e++)
    begin
      wr(tucgp_pkg::IDX_RUN, 32'h0, 4'h1);
      wr(tucgp_pkg::IDX_CTL + 20'd2, 32'((e << 1) | 1), 4'h1);
      wr(tucgp_pkg::IDX_DAT + 20'd2, 32'h0, 4'h3);
      wr(tucgp_pkg::IDX_RUN, 32'h4, 4'h1);
      repeat (10) @(posedge clk);
      pin[2] <= 1'b1;
      repeat (4) @(posedge clk);
      xfer(tucgp_pkg::IDX_DAT + 20'd2, 1'b0, 32'h0, 4'hf);
      cmp(32'(q !== 32'h0), 32'(e == 1 || e == 2));
      wr(tucgp_pkg::IDX_DAT + 20'd2, 32'h0, 4'h3);
      repeat (10) @(posedge clk);
      pin[2] <= 1'b0;
      repeat (4) @(posedge clk);
      xfer(tucgp_pkg::IDX_DAT + 20'd2, 1'b0, 32'h0, 4'hf);
      cmp(32'(q !== 32'h0), 32'(e == 0 || e == 2));
    end
    wr(tucgp_pkg::IDX_RUN, 32'h0, 4'h1);
    wr(tucgp_pkg::IDX_PSC, 32'h0021, 4'h3);
    wr(tucgp_pkg::IDX_RUN, 32'h4, 4'h1);
    wr(tucgp_pkg::IDX_PER, 32'h00, 4'h1);
    for (int n = 0; n < 4; n++)
      rc(tucgp_pkg::IDX_CNT + 20'(n), 32'hffff);
    rc(tucgp_pkg::IDX_RUN, 32'h0);
    wr(tucgp_pkg::IDX_PER, 32'h01, 4'h1);
    rc(tucgp_pkg::IDX_PSC, 32'h0);
    rc(tucgp_pkg::IDX_CNT + 20'd2, 32'hffff);
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    rc(tucgp_pkg::IDX_PER, 32'h0);
    final_report();
  end
endmodule // tucgp_timer_unit_tb
